// ---- pkg/aats_consts.svh ----
// Notes on behaviour
// - Dual enable low selects single-channel source fields
// - Start bit rising edge arms the sequence
// - Channel-1 result copied into channel-1 buffer
// - Source codes 001-011 disconnect external channel
// - Sequence end clears start, sets event flag
// - Nonzero auto count plus start enables PWM sync
// - PWM edge starts blanking, conversion follows it
// - Sequence ends after n rounds from count
// - No retrigger until all n rounds complete
// - Mid-sequence clear waits for busy to fall
// - Buffer holds first result then running sum
// - Dual mode waits gap delay before channel 2
// - After channel 2, wait next PWM edge
// - PWM edges during a round are ignored
// - Blanking interval set by 5-bit field
// - Power enable low switches converter off
// - Results are 12 bits, full scale FFF
// - Dual enable high selects per-channel sources
// - Conversion is 4 sample plus 12 convert clocks
// - Busy flag high during conversion only
`ifndef AATS_CONSTS_SVH
`define AATS_CONSTS_SVH
`define AATS_SAMPLE_CYC 5'h04
`define AATS_CONV_CYC 5'h10
`define AATS_RES_W 12
`define AATS_SUM_W 16
`define AATS_RES_FULL 12'hFFF
`define AATS_SRC_EXT 3'h0
`define AATS_SRC_INT_LO 3'h1
`define AATS_SRC_INT_HI 3'h3
`define AATS_CLK_NS 100
`define AATS_BLANK_UNIT_NS 100
`define AATS_BLANK_UNIT_CYC ((`AATS_BLANK_UNIT_NS + `AATS_CLK_NS - 1) / `AATS_CLK_NS)
`define AATS_GAP_UNIT_NS 100
`define AATS_GAP_UNIT_CYC ((`AATS_GAP_UNIT_NS + `AATS_CLK_NS - 1) / `AATS_CLK_NS)
`define AATS_ROUNDS_01 3
`define AATS_ROUNDS_10 4
`define AATS_ROUNDS_11 8
`endif

// ---- pkg/aats_pkg.sv ----
package aats_pkg;
	typedef enum logic [2:0]
	{
		AATS_IDLE = 3'b000,
		AATS_WAIT_EDGE = 3'b001,
		AATS_BLANK = 3'b010,
		AATS_CONV1 = 3'b011,
		AATS_GAP = 3'b100,
		AATS_CONV2 = 3'b101,
		AATS_DRAIN = 3'b110
	} aats_state_e;
	typedef logic [11:0] aats_res_t;
endpackage

// ---- design/aats_sequencer.sv ----
`timescale 1ns/1ns
`include "aats_consts.svh"
module aats_sequencer #(
	parameter int BLANK_UNIT_CYC = `AATS_BLANK_UNIT_CYC,
	parameter int GAP_UNIT_CYC = `AATS_GAP_UNIT_CYC,
	parameter logic [3:0] ROUNDS_01 = 4'(`AATS_ROUNDS_01),
	parameter logic [3:0] ROUNDS_10 = 4'(`AATS_ROUNDS_10),
	parameter logic [3:0] ROUNDS_11 = 4'(`AATS_ROUNDS_11)
)(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic converter_power_enable_i,
	input wire logic dual_channel_enable_i,
	input wire logic [2:0] input_source_select_i,
	input wire logic [3:0] external_channel_select_i,
	input wire logic ch1_source_is_ext_i,
	input wire logic [3:0] ch1_select_i,
	input wire logic ch2_source_is_ext_i,
	input wire logic [3:0] ch2_select_i,
	input wire logic [1:0] auto_count_select_i,
	input wire logic [4:0] blanking_time_i,
	input wire logic [3:0] channel_gap_delay_i,
	input wire logic start_set_i,
	input wire logic start_clear_i,
	input wire logic event_flag_clear_i,
	input wire logic pwm_trigger_source_i,
	input wire logic conv_clk_en_i,
	input wire aats_pkg::aats_res_t conv_data_i,
	output logic auto_convert_start_o,
	output logic converter_event_flag_o,
	output logic conversion_busy_flag_o,
	output logic conv_power_o,
	output logic conv_sample_o,
	output logic ext_connect_o,
	output logic [3:0] ext_channel_o,
	output logic [2:0] int_source_o,
	output logic [7:0] result_high_o,
	output logic [7:0] result_low_o,
	output logic [7:0] ch1_buffer_high_o,
	output logic [7:0] ch1_buffer_low_o,
	output logic [7:0] ch2_buffer_high_o,
	output logic [7:0] ch2_buffer_low_o
);
	import aats_pkg::*;
	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [3:0] rounds_of(input logic [1:0] code);
		case (code)
			2'h1: rounds_of = ROUNDS_01;
			2'h2: rounds_of = ROUNDS_10;
			2'h3: rounds_of = ROUNDS_11;
			default: rounds_of = 4'h0;
		endcase
	endfunction
	function automatic logic [15:0] acc_add(input logic [15:0] sum, input aats_res_t d,
		input logic first);
		acc_add = first ? {4'h0, d} : 16'(sum + {4'h0, d});
	endfunction
	aats_state_e state;
	logic pwm_s1, pwm_s2, pwm_s3, pwm_edge;
	logic start_q;
	logic [9:0] wait_cnt;
	logic [4:0] conv_cnt;
	logic [3:0] round_cnt;
	logic first_round;
	logic [15:0] acc1, acc2;
	logic conv_done;
	logic [15:0] next_acc;
	////////////////////////////////////////////////////////////////
	// PWM trigger synchroniser and edge
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pwm_s1 <= 1'b0;
			pwm_s2 <= 1'b0;
			pwm_s3 <= 1'b0;
		end
		else
		begin
			pwm_s1 <= pwm_trigger_source_i;
			pwm_s2 <= pwm_s1;
			pwm_s3 <= pwm_s2;
		end
	end
	assign pwm_edge = pwm_s2 && !pwm_s3;
	assign conv_done = (state == AATS_CONV1 || state == AATS_CONV2 || state == AATS_DRAIN)
		&& conv_clk_en_i && conv_cnt == `AATS_CONV_CYC - 5'h01;
	////////////////////////////////////////////////////////////////
	// Start bit and event flag
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			start_q <= 1'b0;
		else if (state == AATS_IDLE && start_set_i && !start_q
			&& auto_count_select_i != 2'h0)
			start_q <= 1'b1;
		else if (start_clear_i)
			start_q <= 1'b0;
		else if (conv_done && state != AATS_DRAIN && round_cnt == 4'h1
			&& (state == AATS_CONV2 || !dual_channel_enable_i))
			start_q <= 1'b0;
	end
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			converter_event_flag_o <= 1'b0;
		else if (conv_done && state != AATS_DRAIN && round_cnt == 4'h1 && start_q
			&& (state == AATS_CONV2 || !dual_channel_enable_i))
			converter_event_flag_o <= 1'b1;
		else if (event_flag_clear_i)
			converter_event_flag_o <= 1'b0;
	end
	assign auto_convert_start_o = start_q;
	////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= AATS_IDLE;
			wait_cnt <= 10'h000;
			conv_cnt <= 5'h00;
			round_cnt <= 4'h0;
			first_round <= 1'b0;
		end
		else
		begin
			case (state)
				AATS_IDLE:
					if (start_set_i && !start_q && auto_count_select_i != 2'h0)
					begin
						round_cnt <= rounds_of(auto_count_select_i);
						first_round <= 1'b1;
						state <= AATS_WAIT_EDGE;
					end
				AATS_WAIT_EDGE:
					if (!start_q)
						state <= AATS_IDLE;
					else if (pwm_edge)
					begin
						wait_cnt <= 10'(blanking_time_i * BLANK_UNIT_CYC);
						state <= AATS_BLANK;
					end
				AATS_BLANK:
					if (!start_q)
						state <= AATS_IDLE;
					else if (wait_cnt == 10'h000)
					begin
						conv_cnt <= 5'h00;
						state <= AATS_CONV1;
					end
					else
						wait_cnt <= wait_cnt - 10'h001;
				AATS_CONV1, AATS_CONV2:
					if (conv_done)
					begin
						conv_cnt <= 5'h00;
						if (state == AATS_CONV1 && dual_channel_enable_i)
						begin
							wait_cnt <= 10'(channel_gap_delay_i * GAP_UNIT_CYC);
							state <= AATS_GAP;
						end
						else
						begin
							first_round <= 1'b0;
							round_cnt <= round_cnt - 4'h1;
							state <= (round_cnt == 4'h1) ? AATS_IDLE : AATS_WAIT_EDGE;
						end
					end
					else
					begin
						// Keep counting so the drained conversion stays 16 clocks
						if (conv_clk_en_i)
							conv_cnt <= conv_cnt + 5'h01;
						if (!start_q)
							state <= AATS_DRAIN;
					end
				AATS_GAP:
					if (!start_q)
						state <= AATS_IDLE;
					else if (wait_cnt == 10'h000)
						state <= AATS_CONV2;
					else
						wait_cnt <= wait_cnt - 10'h001;
				AATS_DRAIN:
					if (conv_done)
					begin
						conv_cnt <= 5'h00;
						state <= AATS_IDLE;
					end
					else if (conv_clk_en_i)
						conv_cnt <= conv_cnt + 5'h01;
				default:
					state <= AATS_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// Converter drive
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			conversion_busy_flag_o <= 1'b0;
			conv_sample_o <= 1'b0;
			conv_power_o <= 1'b0;
			ext_connect_o <= 1'b0;
			ext_channel_o <= 4'h0;
			int_source_o <= 3'h0;
		end
		else
		begin
			conv_power_o <= converter_power_enable_i;
			conversion_busy_flag_o <= (state == AATS_CONV1 || state == AATS_CONV2
				|| state == AATS_DRAIN) && !conv_done;
			conv_sample_o <= (state == AATS_CONV1 || state == AATS_CONV2)
				&& conv_cnt < `AATS_SAMPLE_CYC;
			if (!dual_channel_enable_i)
			begin
				ext_connect_o <= !(input_source_select_i >= `AATS_SRC_INT_LO
					&& input_source_select_i <= `AATS_SRC_INT_HI);
				ext_channel_o <= external_channel_select_i;
				int_source_o <= input_source_select_i;
			end
			else if (state == AATS_GAP || state == AATS_CONV2)
			begin
				ext_connect_o <= ch2_source_is_ext_i;
				ext_channel_o <= ch2_select_i;
				int_source_o <= ch2_select_i[2:0];
			end
			else
			begin
				ext_connect_o <= ch1_source_is_ext_i;
				ext_channel_o <= ch1_select_i;
				int_source_o <= ch1_select_i[2:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Results and accumulation
	always_comb
	begin
		next_acc = acc_add(state == AATS_CONV2 ? acc2 : acc1, conv_data_i, first_round);
	end
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc1 <= 16'h0000;
			acc2 <= 16'h0000;
			result_high_o <= 8'h00;
			result_low_o <= 8'h00;
		end
		else if (conv_done && state != AATS_DRAIN)
		begin
			result_high_o <= {4'h0, conv_data_i[11:8]};
			result_low_o <= conv_data_i[7:0];
			if (state == AATS_CONV1)
				acc1 <= next_acc;
			else
				acc2 <= next_acc;
		end
	end
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ch1_buffer_high_o <= 8'h00;
			ch1_buffer_low_o <= 8'h00;
			ch2_buffer_high_o <= 8'h00;
			ch2_buffer_low_o <= 8'h00;
		end
		else
		begin
			ch1_buffer_high_o <= acc1[15:8];
			ch1_buffer_low_o <= acc1[7:0];
			ch2_buffer_high_o <= acc2[15:8];
			ch2_buffer_low_o <= acc2[7:0];
		end
	end
	////////////////////////////////////////////////////////////////
	// Checks
	arm_needs_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$rose(start_q) |-> $past(auto_count_select_i) != 2'h0 && $past(state) == AATS_IDLE)
		else $error("start armed without count");
	no_retrigger_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == AATS_CONV1 || state == AATS_GAP || state == AATS_CONV2
		|| state == AATS_DRAIN) && pwm_edge |=> state != AATS_BLANK)
		else $error("edge retriggered round");
	edge_blanks_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state == AATS_WAIT_EDGE && start_q && pwm_edge |=> state == AATS_BLANK)
		else $error("edge did not start blanking");
	done_sets_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$fell(start_q) && !$past(start_clear_i) |-> converter_event_flag_o)
		else $error("end without event flag");
	drain_holds_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state == AATS_DRAIN && !conv_done |=> state == AATS_DRAIN)
		else $error("drain left early");
	busy_conv_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state == AATS_CONV1 && !conv_done |=> conversion_busy_flag_o)
		else $error("busy low during conversion");
	gap_to_ch2_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state == AATS_GAP && start_q && wait_cnt == 10'h000 |=> state == AATS_CONV2)
		else $error("gap did not reach channel 2");
	internal_disconnect_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!dual_channel_enable_i && input_source_select_i == 3'h2 |=> !ext_connect_o)
		else $error("external left connected");
	power_follow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!converter_power_enable_i |=> !conv_power_o)
		else $error("power not removed");
endmodule // aats_sequencer

// ---- tb/aats_far_model.sv ----
`timescale 1ns/1ns
module aats_far_model #(
	parameter int PWM_PER = 60
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire aats_pkg::aats_res_t value_i,
	output logic pwm_o,
	output logic clk_en_o,
	output aats_pkg::aats_res_t data_o
);
	import aats_pkg::*;
	int cnt;
	////////////////////////////////////////////////////////////////
	// Pwm carrier and converter clock enable at half rate
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt <= 0;
			pwm_o <= 1'b0;
			clk_en_o <= 1'b0;
		end
		else
		begin
			cnt <= (cnt + 1) % PWM_PER;
			pwm_o <= run_i && (cnt < PWM_PER / 2);
			clk_en_o <= ~clk_en_o;
		end
	end
	// Converter result level
	assign data_o = value_i;
endmodule // aats_far_model

// ---- tb/aats_sequencer_test.sv ----
`timescale 1ns/1ns
`include "aats_consts.svh"
module aats_sequencer_test;
	import aats_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic pwr = 1'b1, dual = 1'b0, run = 1'b1, set_s = 1'b0, clr_s = 1'b0, fclr = 1'b0;
	logic [2:0] src = 3'h0;
	logic [3:0] gap = 4'h3;
	logic [4:0] blank = 5'h05;
	logic sample_o;
	logic [2:0] isrc;
	logic [1:0] cnt_sel = 2'h0;
	aats_res_t value = 12'h123;
	logic pwm, clk_en, start_o, flag_o, busy_o, pwr_o, ext_o;
	aats_res_t data;
	logic [3:0] ech_o;
	logic [7:0] rh, rl, b1h, b1l, b2h, b2l;
	int fails = 0, total_checks = 0, cycles = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	aats_far_model aats_far_model_inst (.clk_i(clk_sys_i), .rst_i(rst_i), .run_i(run),
		.value_i(value), .pwm_o(pwm), .clk_en_o(clk_en), .data_o(data));
	aats_sequencer aats_sequencer_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.converter_power_enable_i(pwr), .dual_channel_enable_i(dual),
		.input_source_select_i(src), .external_channel_select_i(4'h5),
		.ch1_source_is_ext_i(1'b1), .ch1_select_i(4'h7), .ch2_source_is_ext_i(1'b0),
		.ch2_select_i(4'h2), .auto_count_select_i(cnt_sel), .blanking_time_i(blank),
		.channel_gap_delay_i(gap), .start_set_i(set_s), .start_clear_i(clr_s),
		.event_flag_clear_i(fclr), .pwm_trigger_source_i(pwm), .conv_clk_en_i(clk_en),
		.conv_data_i(data), .auto_convert_start_o(start_o), .converter_event_flag_o(flag_o),
		.conversion_busy_flag_o(busy_o), .conv_power_o(pwr_o), .conv_sample_o(sample_o),
		.ext_connect_o(ext_o), .ext_channel_o(ech_o), .int_source_o(isrc),
		.result_high_o(rh), .result_low_o(rl), .ch1_buffer_high_o(b1h),
		.ch1_buffer_low_o(b1l), .ch2_buffer_high_o(b2h), .ch2_buffer_low_o(b2l));
	////////////////////////////////////////////////////////////////
	// Shared tasks
	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task pulse_set;
		set_s = 1'b1;
		tick(1);
		set_s = 1'b0;
		tick(1);
	endtask
	// Poll start until hardware drops it, retrying a start midway
	task wait_start_low;
		int k;
		k = 0;
		while (start_o === 1'b1 && k < 3000)
		begin
			tick(1);
			k++;
			set_s = (k == 50);
		end
	endtask
	task run_seq(input logic [1:0] c, input aats_res_t v, input int rounds);
		cnt_sel = c;
		value = v;
		pulse_set;
		check(16'(start_o), 16'h1);
		wait_start_low;
		// Buffers follow the accumulators one clock later
		tick(1);
		check(16'(start_o), 16'h0);
		check(16'(flag_o), 16'h1);
		check({b1h, b1l}, 16'(rounds * v));
		check({rh, rl}, {4'h0, v});
		if (dual)
		begin
			check({b2h, b2l}, 16'(rounds * v));
			check({11'h0, ext_o, ech_o}, 16'h17);
		end
		fclr = 1'b1;
		tick(1);
		fclr = 1'b0;
		tick(1);
		check(16'(flag_o), 16'h0);
	endtask
	////////////////////////////////////////////////////////////////
	// Timeout
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////
	// Tests
	initial
	begin
		tick(10);
		rst_i = 1'b0;
		check({13'h0, start_o, flag_o, busy_o}, 16'h0);
		check({b1h, b1l}, 16'h0);
		pulse_set;
		check(16'(start_o), 16'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			src = 3'(i);
			tick(2);
			check({11'h0, ext_o, ech_o}, (i == 0) ? 16'h15 : 16'h05);
			check({13'h0, isrc}, 16'(i));
		end
		src = 3'h0;
		pwr = 1'b0;
		tick(2);
		check(16'(pwr_o), 16'h0);
		pwr = 1'b1;
		tick(2);
		check(16'(pwr_o), 16'h1);
		$display("test routing done");
		run_seq(2'h1, 12'h123, `AATS_ROUNDS_01);
		run_seq(2'h2, 12'hFFF, `AATS_ROUNDS_10);
		run_seq(2'h3, 12'hFFF, `AATS_ROUNDS_11);
		$display("test single done");
		dual = 1'b1;
		blank = 5'h00;
		run_seq(2'h1, 12'h2A5, `AATS_ROUNDS_01);
		dual = 1'b0;
		$display("test dual done");
		cnt_sel = 2'h1;
		pulse_set;
		for (int k = 0; k < 400 && busy_o !== 1'b1; k++)
			tick(1);
		check(16'(busy_o), 16'h1);
		check(16'(sample_o), 16'h1);
		run = 1'b0;
		clr_s = 1'b1;
		tick(1);
		clr_s = 1'b0;
		tick(1);
		check({14'h0, start_o, busy_o}, 16'h1);
		for (int k = 0; k < 40 && busy_o !== 1'b0; k++)
			tick(1);
		check(16'(busy_o), 16'h0);
		check(16'(sample_o), 16'h0);
		tick(2);
		run = 1'b1;
		run_seq(2'h1, 12'h0F1, `AATS_ROUNDS_01);
		$display("test abort done");
		final_report;
	end
endmodule // aats_sequencer_test
